// ===== rtl/bridge_routing_regs.svh
// Register map, field positions, reset values and fixed decode ranges
// for the legacy video and I/O routing decode of the graphics bridge.
// Assumes byte addresses on a 32-bit APB, one register per aligned word.
`ifndef BRIDGE_ROUTING_REGS_SVH
`define BRIDGE_ROUTING_REGS_SVH

// ==========================================================
// Register byte addresses
`define ADDR_BRIDGE_CONTROL 8'h00
`define ADDR_IO_BASE        8'h04
`define ADDR_IO_LIMIT       8'h08
`define ADDR_MEM_BASE       8'h0c
`define ADDR_MEM_LIMIT      8'h10
`define ADDR_PREF_BASE      8'h14
`define ADDR_PREF_LIMIT     8'h18
`define ADDR_ROUTE_STATUS   8'h1c

// ==========================================================
// Bridge control fields
`define CTRL_FB2B_BIT       7
`define CTRL_SEC_RESET_BIT  6
`define CTRL_ABORT_MODE_BIT 5
`define CTRL_VIDEO_BIT      3
`define CTRL_ALIAS_BIT      2
`define CTRL_RESET_VALUE    1'b0

// ==========================================================
// Window fields and reset values
`define IO_FIELD_MSB        15
`define IO_FIELD_LSB        12
`define MEM_FIELD_MSB       15
`define MEM_FIELD_LSB       4
`define IO_BASE_RESET       4'hf
`define IO_LIMIT_RESET      4'h0
`define MEM_BASE_RESET      12'hfff
`define MEM_LIMIT_RESET     12'h000
`define IO_LOW_ZERO         12'h000
`define IO_LOW_ONES         12'hfff
`define MEM_LOW_ZERO        20'h00000
`define MEM_LOW_ONES        20'hfffff

// ==========================================================
// Route status fields
`define ST_VALID_BIT        0
`define ST_GFX_BIT          1
`define ST_VIDEO_BIT        2
`define ST_ALIAS_BIT        3
`define ST_WINDOW_BIT       4
`define ST_IO_BIT           5

// ==========================================================
// Fixed legacy video ranges
`define VIDEO_MEM_LO        32'h000a_0000
`define VIDEO_MEM_HI        32'h000b_ffff
`define VIDEO_PORT_A_LO     10'h3b0
`define VIDEO_PORT_A_HI     10'h3bb
`define VIDEO_PORT_B_LO     10'h3c0
`define VIDEO_PORT_B_HI     10'h3df
`define ALIAS_MSB           9
`define ALIAS_LSB           8
`define ALIAS_LOW_QUARTER   2'h0
`define ALL_ONES_WORD       32'hffff_ffff

`endif

// ===== rtl/routing_pkg.sv
// Types used by the routing decode; its window decoder uses none of them.
// Assumes the constants header is compiled alongside.
package routing_pkg;

	// ==========================================================
	// APB answer sequencing
	typedef enum logic [0:0] {
		BUS_SETUP,
		BUS_ANSWER
	} bus_phase_t;

endpackage : routing_pkg

// ===== rtl/route_window_decode.sv
// Combinational route decision for one host access.
// Assumes window registers and control bits are held stable by the caller.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_routing_regs.svh"

module route_window_decode (
	input  wire logic        is_io,
	input  wire logic [31:0] addr,
	input  wire logic        video_forward,
	input  wire logic        alias_filter,
	input  wire logic [3:0]  io_base,
	input  wire logic [3:0]  io_limit,
	input  wire logic [11:0] mem_base,
	input  wire logic [11:0] mem_limit,
	input  wire logic [11:0] pref_base,
	input  wire logic [11:0] pref_limit,
	output logic             to_graphics,
	output logic             video_hit,
	output logic             alias_blocked,
	output logic             window_hit
);

	// ==========================================================
	// Helpers
	function automatic logic port_in_range(input logic [9:0] a, input logic [9:0] lo,
		input logic [9:0] hi);
		port_in_range = (a >= lo) && (a <= hi);
	endfunction : port_in_range

	// Base has zero low bits, limit all-ones low bits
	function automatic logic mem_in_window(input logic [31:0] a, input logic [11:0] b,
		input logic [11:0] l);
		mem_in_window = (a >= {b, `MEM_LOW_ZERO}) && (a <= {l, `MEM_LOW_ONES});
	endfunction : mem_in_window

	logic io_win;
	logic mem_win;
	logic video_port;
	logic video_mem;

	// Window hits; I/O space is 64K so only the low half-word counts
	assign io_win  = (addr[15:0] >= {io_base, `IO_LOW_ZERO}) &&
	                 (addr[15:0] <= {io_limit, `IO_LOW_ONES});
	assign mem_win = mem_in_window(addr, mem_base, mem_limit) ||
	                 mem_in_window(addr, pref_base, pref_limit);

	// Port ranges look at bits 9:0 only, so every ISA alias matches
	assign video_port = port_in_range(addr[9:0], `VIDEO_PORT_A_LO, `VIDEO_PORT_A_HI) ||
	                    port_in_range(addr[9:0], `VIDEO_PORT_B_LO, `VIDEO_PORT_B_HI);
	assign video_mem  = (addr >= `VIDEO_MEM_LO) && (addr <= `VIDEO_MEM_HI);

	// Final decision: video override first, then windows trimmed by the filter
	always_comb begin
		video_hit     = video_forward && (is_io ? video_port : video_mem);
		window_hit    = is_io ? io_win : mem_win;
		alias_blocked = is_io && io_win && alias_filter &&
		                (addr[`ALIAS_MSB:`ALIAS_LSB] != `ALIAS_LOW_QUARTER);
		to_graphics   = video_hit || (window_hit && !alias_blocked);
	end

endmodule : route_window_decode
`default_nettype wire

// ===== rtl/legacy_video_io_routing_decode.sv
// Routing decode of the graphics bridge: APB register file, host access
// steering between graphics port and hub path, master-abort completion
// and the graphics port reset, which follows system reset only.
// Assumes host requests and graphics completions come from pclk logic.
// A register write lands on the edge that samples pready, so a host
// request taken on that same edge still sees the old windows.
// The graphics port reset has no software source at all: only presetn
// raises it, so no stray write can knock the port over.
// Limitation: route_status holds only the latest request; requests on
// back-to-back cycles overwrite it.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_routing_regs.svh"

module legacy_video_io_routing_decode (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Host access to be steered
	input  wire logic        host_req_valid,
	input  wire logic        host_req_io,
	input  wire logic [31:0] host_req_addr,
	output logic             route_valid,
	output logic             route_to_graphics,
	output logic             route_to_hub,
	// Completion of cycles the bridge masters on the graphics port
	input  wire logic        gfx_cycle_done,
	input  wire logic        gfx_cycle_abort,
	input  wire logic        gfx_cycle_write,
	input  wire logic [31:0] gfx_read_data,
	output logic             gfx_result_valid,
	output logic [31:0]      gfx_result_data,
	output logic             gfx_write_kept,
	// Graphics port reset, active high
	output logic             graphics_port_reset
);

	// ==========================================================
	// State
	typedef struct packed {
		// APB answer
		routing_pkg::bus_phase_t phase;
		logic [31:0]             rdata;
		logic                    ready;
		logic                    slverr;
		// Routing controls and window bounds
		logic                    video_forward;
		logic                    alias_filter;
		logic [3:0]              io_base;
		logic [3:0]              io_limit;
		logic [11:0]             mem_base;
		logic [11:0]             mem_limit;
		logic [11:0]             pref_base;
		logic [11:0]             pref_limit;
		// Last decision, readable by software
		logic [5:0]              status;
		// Route answer
		logic                    route_valid;
		logic                    route_gfx;
		logic                    route_hub;
		// Completion answer
		logic                    res_valid;
		logic [31:0]             res_data;
		logic                    res_kept;
		// Graphics port reset
		logic                    port_reset;
	} state_t;

	// Current state and the value it takes on the next edge
	state_t state;
	state_t next_state;

	// Decoder results for the request now on the host inputs
	logic dec_gfx;
	logic dec_video;
	logic dec_alias;
	logic dec_window;

	// ==========================================================
	// Route decision for the current host request; the decoder is pure
	// logic and its answer is registered below with the request, which
	// makes the route answer one cycle late but glitch free.
	route_window_decode u_decode (
		.is_io         (host_req_io),
		.addr          (host_req_addr),
		.video_forward (state.video_forward),
		.alias_filter  (state.alias_filter),
		.io_base       (state.io_base),
		.io_limit      (state.io_limit),
		.mem_base      (state.mem_base),
		.mem_limit     (state.mem_limit),
		.pref_base     (state.pref_base),
		.pref_limit    (state.pref_limit),
		.to_graphics   (dec_gfx),
		.video_hit     (dec_video),
		.alias_blocked (dec_alias),
		.window_hit    (dec_window)
	);

	// ==========================================================
	// Register read and decode helpers
	// Offsets that answer without an error
	function automatic logic addr_mapped(input logic [7:0] a);
		case (a)
			`ADDR_BRIDGE_CONTROL,
			`ADDR_IO_BASE,
			`ADDR_IO_LIMIT,
			`ADDR_MEM_BASE,
			`ADDR_MEM_LIMIT,
			`ADDR_PREF_BASE,
			`ADDR_PREF_LIMIT,
			`ADDR_ROUTE_STATUS: addr_mapped = 1'b1;
			default:            addr_mapped = 1'b0;
		endcase
	endfunction : addr_mapped

	// Place a 12-bit memory bound in its register field
	function automatic logic [31:0] mem_field(input logic [11:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`MEM_FIELD_MSB:`MEM_FIELD_LSB] = v;
		mem_field = w;
	endfunction : mem_field

	// Place a 4-bit I/O bound in its register field
	function automatic logic [31:0] io_field(input logic [3:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`IO_FIELD_MSB:`IO_FIELD_LSB] = v;
		io_field = w;
	endfunction : io_field

	// ==========================================================
	// Write field extraction; reserved low bits of a bound are dropped
	function automatic logic [11:0] mem_bound(input logic [31:0] d);
		mem_bound = d[`MEM_FIELD_MSB:`MEM_FIELD_LSB];
	endfunction : mem_bound

	function automatic logic [3:0] io_bound(input logic [31:0] d);
		io_bound = d[`IO_FIELD_MSB:`IO_FIELD_LSB];
	endfunction : io_bound

	// Read mux; unlisted and hardwired bits stay zero
	function automatic logic [31:0] read_word(input logic [7:0] a, input state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			`ADDR_BRIDGE_CONTROL: begin
				// Hardwired bits spelt out so the intent survives edits
				w[`CTRL_FB2B_BIT]       = `CTRL_RESET_VALUE;
				w[`CTRL_SEC_RESET_BIT]  = `CTRL_RESET_VALUE;
				w[`CTRL_ABORT_MODE_BIT] = `CTRL_RESET_VALUE;
				w[`CTRL_VIDEO_BIT]      = s.video_forward;
				w[`CTRL_ALIAS_BIT]      = s.alias_filter;
			end
			`ADDR_IO_BASE:      w = io_field(s.io_base);
			`ADDR_IO_LIMIT:     w = io_field(s.io_limit);
			`ADDR_MEM_BASE:     w = mem_field(s.mem_base);
			`ADDR_MEM_LIMIT:    w = mem_field(s.mem_limit);
			`ADDR_PREF_BASE:    w = mem_field(s.pref_base);
			`ADDR_PREF_LIMIT:   w = mem_field(s.pref_limit);
			`ADDR_ROUTE_STATUS: w[`ST_IO_BIT:`ST_VALID_BIT] = s.status;
			default:            w = 32'h0000_0000;
		endcase
		read_word = w;
	endfunction : read_word

	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;

		// APB: one wait cycle, answer registered, write lands with pready.
		// Read data is built from the state of the first access edge, so a
		// read never shows half of an update in flight.
		case (state.phase)
			routing_pkg::BUS_SETUP: begin
				// Idle: answer lines low until an access phase is seen
				next_state.ready  = 1'b0;
				next_state.slverr = 1'b0;
				if (psel && penable) begin
					next_state.phase  = routing_pkg::BUS_ANSWER;
					next_state.ready  = 1'b1;
					next_state.slverr = !addr_mapped(paddr);
					next_state.rdata  = pwrite ? 32'h0000_0000 : read_word(paddr, state);
				end
			end
			routing_pkg::BUS_ANSWER: begin
				// Answer cycle: a write lands on this edge, then back to idle
				next_state.phase  = routing_pkg::BUS_SETUP;
				next_state.ready  = 1'b0;
				next_state.slverr = 1'b0;
				if (psel && penable && pwrite) begin
					// Only the two routing bits are writable; the rest is ignored.
					// Fast back-to-back, secondary reset and abort mode have no
					// storage at all, so no write can ever set them.
					case (paddr)
						`ADDR_BRIDGE_CONTROL: begin
							next_state.video_forward = pwdata[`CTRL_VIDEO_BIT];
							next_state.alias_filter  = pwdata[`CTRL_ALIAS_BIT];
						end
						`ADDR_IO_BASE:    next_state.io_base    = io_bound(pwdata);
						`ADDR_IO_LIMIT:   next_state.io_limit   = io_bound(pwdata);
						`ADDR_MEM_BASE:   next_state.mem_base   = mem_bound(pwdata);
						`ADDR_MEM_LIMIT:  next_state.mem_limit  = mem_bound(pwdata);
						`ADDR_PREF_BASE:  next_state.pref_base  = mem_bound(pwdata);
						`ADDR_PREF_LIMIT: next_state.pref_limit = mem_bound(pwdata);
						default: ;
					endcase
				end
			end
			default: begin
				// Unused encoding: fall back to idle
				next_state.phase = routing_pkg::BUS_SETUP;
				next_state.ready = 1'b0;
			end
		endcase

		// Host steering; exactly one target per request. The hub path is the
		// default target, which is also where alias-filtered I/O must land.
		next_state.route_valid = host_req_valid;
		next_state.route_gfx   = host_req_valid && dec_gfx;
		next_state.route_hub   = host_req_valid && !dec_gfx;
		// Status keeps the last decision so software can see why it went there
		if (host_req_valid) begin
			next_state.status = 6'h00;
			next_state.status[`ST_VALID_BIT]  = 1'b1;
			next_state.status[`ST_GFX_BIT]    = dec_gfx;
			next_state.status[`ST_VIDEO_BIT]  = dec_video;
			next_state.status[`ST_ALIAS_BIT]  = dec_alias;
			next_state.status[`ST_WINDOW_BIT] = dec_window;
			next_state.status[`ST_IO_BIT]     = host_req_io;
		end

		// Master abort: reads complete as all ones, writes are discarded.
		// A write carries no data back; an aborted one is not reported kept.
		next_state.res_valid = gfx_cycle_done;
		next_state.res_kept  = gfx_cycle_done && gfx_cycle_write && !gfx_cycle_abort;
		if (gfx_cycle_done) begin
			if (gfx_cycle_write)
				next_state.res_data = 32'h0000_0000;
			else if (gfx_cycle_abort)
				next_state.res_data = `ALL_ONES_WORD;
			else
				next_state.res_data = gfx_read_data;
		end

		// No register can drive this; it falls one edge after system reset
		next_state.port_reset = 1'b0;
	end

	// ==========================================================
	// State register; port reset is held high while in reset. The reset
	// is a level, so the graphics port stays in reset as long as presetn.
	// Every field takes a constant here; nothing is loaded from inputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state               <= '0;
			state.phase         <= routing_pkg::BUS_SETUP;
			state.video_forward <= `CTRL_RESET_VALUE;
			state.alias_filter  <= `CTRL_RESET_VALUE;
			state.io_base       <= `IO_BASE_RESET;
			state.io_limit      <= `IO_LIMIT_RESET;
			state.mem_base      <= `MEM_BASE_RESET;
			state.mem_limit     <= `MEM_LIMIT_RESET;
			state.pref_base     <= `MEM_BASE_RESET;
			state.pref_limit    <= `MEM_LIMIT_RESET;
			state.port_reset    <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register,
	// so no output can glitch while the decoder settles
	// APB answer
	assign prdata              = state.rdata;
	assign pready              = state.ready;
	assign pslverr             = state.slverr;

	// Route answer
	assign route_valid         = state.route_valid;
	assign route_to_graphics   = state.route_gfx;
	assign route_to_hub        = state.route_hub;

	// Completion answer
	assign gfx_result_valid    = state.res_valid;
	assign gfx_result_data     = state.res_data;
	assign gfx_write_kept      = state.res_kept;

	// Port reset, system reset only
	assign graphics_port_reset = state.port_reset;

endmodule : legacy_video_io_routing_decode
`default_nettype wire

// ===== bench/routing_decode_sva.sv
// Checker for the routing decode: APB answer, routing and completion timing.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_routing_regs.svh"

module routing_decode_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        host_req_valid,
	input wire logic        route_valid,
	input wire logic        route_to_graphics,
	input wire logic        route_to_hub,
	input wire logic        gfx_cycle_done,
	input wire logic        gfx_cycle_abort,
	input wire logic        gfx_cycle_write,
	input wire logic        gfx_result_valid,
	input wire logic [31:0] gfx_result_data,
	input wire logic        gfx_write_kept,
	input wire logic        graphics_port_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Steps of an access
	sequence apb_access;
		psel && penable && !pready;
	endsequence
	sequence ctrl_read;
		apb_access ##0 (!pwrite && paddr == `ADDR_BRIDGE_CONTROL);
	endsequence
	sequence aborted_read;
		gfx_cycle_done && gfx_cycle_abort && !gfx_cycle_write;
	endsequence

	// ==========================================================
	// Properties
	apb_answer_a: assert property (apb_access |=> pready ##1 !pready)
		else $error("pready not a single pulse after access");
	unmapped_err_a: assert property (apb_access ##0 paddr[1:0] == 2'h0
		|=> pslverr == (paddr > `ADDR_ROUTE_STATUS))
		else $error("pslverr does not follow address map");
	ctrl_zero_a: assert property (ctrl_read
		|=> (prdata & 32'hffff_fff3) == 32'h0)
		else $error("control read shows hardwired bits set");
	gport_reset_a: assert property ($past(presetn) |-> !graphics_port_reset)
		else $error("graphics port reset outside system reset");
	route_answer_a: assert property (host_req_valid
		|=> route_valid && (route_to_graphics ^ route_to_hub))
		else $error("route answer missing or not exclusive");
	route_quiet_a: assert property (!host_req_valid |=> !route_valid)
		else $error("route answer without request");
	abort_read_a: assert property (aborted_read
		|=> gfx_result_valid && gfx_result_data == 32'hffff_ffff)
		else $error("aborted read did not return all ones");
	write_drop_a: assert property (gfx_cycle_done && gfx_cycle_write
		|=> gfx_result_valid && gfx_write_kept != $past(gfx_cycle_abort))
		else $error("write kept flag wrong for completion");
	result_quiet_a: assert property (!gfx_cycle_done |=> !gfx_result_valid && !gfx_write_kept)
		else $error("completion result without done");
endmodule : routing_decode_sva

bind legacy_video_io_routing_decode routing_decode_sva i_routing_decode_sva (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .host_req_valid, .route_valid,
	.route_to_graphics, .route_to_hub, .gfx_cycle_done, .gfx_cycle_abort, .gfx_cycle_write,
	.gfx_result_valid, .gfx_result_data, .gfx_write_kept, .graphics_port_reset);
`default_nettype wire

// ===== bench/gfx_target_model.sv
// Graphics target model: ends one bridge-mastered cycle per start pulse.
// Assumes the bench raises start for one pclk cycle per completion.
`timescale 1ns/10ps
`default_nettype none

module gfx_target_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic        give_abort,
	input  wire logic        give_write,
	input  wire logic [31:0] give_data,
	output logic             gfx_cycle_done,
	output logic             gfx_cycle_abort,
	output logic             gfx_cycle_write,
	output logic [31:0]      gfx_read_data
);
	// Qualifiers toggle between completions so stale values never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gfx_cycle_done  <= 1'b0;
			gfx_cycle_abort <= 1'b0;
			gfx_cycle_write <= 1'b0;
			gfx_read_data   <= 32'h0;
		end else begin
			gfx_cycle_done  <= start;
			gfx_cycle_abort <= start ? give_abort : ~gfx_cycle_abort;
			gfx_cycle_write <= start ? give_write : ~gfx_cycle_write;
			gfx_read_data   <= start ? give_data : ~gfx_read_data;
		end
	end
endmodule : gfx_target_model
`default_nettype wire

// ===== bench/tb_legacy_video_io_routing_decode.sv
// Bench for the routing decode: APB registers, host routing, completions.
// Assumes the checker binds itself and the target model drives completions.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_routing_regs.svh"

module tb_legacy_video_io_routing_decode;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, host_req_addr, gfx_read_data, gfx_result_data, give_data;
	logic        host_req_valid, host_req_io, route_valid, route_to_graphics, route_to_hub;
	logic        gfx_cycle_done, gfx_cycle_abort, gfx_cycle_write, gfx_result_valid;
	logic        gfx_write_kept, graphics_port_reset, start, give_abort, give_write;
	int          num_errors, n_checks;
	logic [31:0] rst_val [8] = '{32'h0, 32'hf000, 32'h0, 32'hfff0, 32'h0, 32'hfff0, 32'h0, 32'h0};

	legacy_video_io_routing_decode i_legacy_video_io_routing_decode (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_req_valid,
		.host_req_io, .host_req_addr, .route_valid, .route_to_graphics, .route_to_hub,
		.gfx_cycle_done, .gfx_cycle_abort, .gfx_cycle_write, .gfx_read_data, .gfx_result_valid,
		.gfx_result_data, .gfx_write_kept, .graphics_port_reset);
	gfx_target_model i_gfx_target_model (.pclk, .presetn, .start, .give_abort, .give_write,
		.give_data, .gfx_cycle_done, .gfx_cycle_abort, .gfx_cycle_write, .gfx_read_data);

	// 20 MHz clock
	always #25 pclk = ~pclk;

	// ==========================================================
	// Access tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Request held until pready is sampled high; only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic route(input logic io, input logic [31:0] a, input logic gfx);
		@(posedge pclk);
		host_req_valid <= 1'b1;
		host_req_io <= io;
		host_req_addr <= a;
		@(posedge pclk);
		host_req_valid <= 1'b0;
		@(posedge pclk);
		chk("route_to_graphics", route_to_graphics, gfx);
		chk("route_to_hub", route_to_hub, !gfx);
	endtask : route

	task automatic gfx(input logic ab, input logic wr, input logic [31:0] exp, input logic kept);
		@(posedge pclk);
		start <= 1'b1;
		give_abort <= ab;
		give_write <= wr;
		give_data <= 32'h1234_5678;
		@(posedge pclk);
		start <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("gfx_result_valid", gfx_result_valid, 1'b1);
		chk("gfx_result_data", gfx_result_data, exp);
		chk("gfx_write_kept", gfx_write_kept, kept);
	endtask : gfx

	task automatic stop_test;
		$display("Counts: %0d checks, %0d mismatches", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200us;
		num_errors++;
		$display("Watchdog expired");
		stop_test;
	end

	// ==========================================================
	// Test sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, host_req_valid, host_req_io} = 7'h0;
		{start, give_abort, give_write} = 3'h0;
		{paddr, pwdata, host_req_addr, give_data} = 104'h0;
		repeat (6) @(posedge pclk);
		chk("graphics_port_reset", graphics_port_reset, 1'b1);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", rd, rst_val[i]);
		end
		$display("Reset values done");
		apb(1'b1, `ADDR_BRIDGE_CONTROL, 32'hffff_ffff);
		apb(1'b0, `ADDR_BRIDGE_CONTROL, 32'h0);
		chk("bridge_control", rd, 32'h0000_000c);
		chk("graphics_port_reset", graphics_port_reset, 1'b0);
		apb(1'b1, 8'h20, 32'h1);
		chk("pslverr", err, 1'b1);
		apb(1'b1, `ADDR_MEM_BASE, 32'hffff_0105);
		apb(1'b0, `ADDR_MEM_BASE, 32'h0);
		chk("mem_window_base", rd, 32'h0000_0100);
		$display("Control register done");
		route(1'b0, 32'h000a_0000, 1'b1);
		route(1'b0, 32'h000b_ffff, 1'b1);
		route(1'b0, 32'h0009_ffff, 1'b0);
		route(1'b0, 32'h000c_0000, 1'b0);
		route(1'b1, 32'h0000_03b0, 1'b1);
		route(1'b1, 32'h0000_03bb, 1'b1);
		route(1'b1, 32'h0000_03bc, 1'b0);
		route(1'b1, 32'h0000_03c0, 1'b1);
		route(1'b1, 32'h0000_03df, 1'b1);
		route(1'b1, 32'h0000_03e0, 1'b0);
		route(1'b1, 32'h0000_ffc5, 1'b1);
		apb(1'b1, `ADDR_BRIDGE_CONTROL, 32'h0);
		route(1'b0, 32'h000a_0000, 1'b0);
		route(1'b1, 32'h0000_03c0, 1'b0);
		$display("Video forwarding done");
		apb(1'b1, `ADDR_IO_BASE, 32'h0);
		apb(1'b1, `ADDR_IO_LIMIT, 32'h0);
		route(1'b1, 32'h0000_0100, 1'b1);
		route(1'b1, 32'h0000_03c0, 1'b1);
		apb(1'b1, `ADDR_BRIDGE_CONTROL, 32'h4);
		route(1'b1, 32'h0000_0100, 1'b0);
		apb(1'b0, `ADDR_ROUTE_STATUS, 32'h0);
		chk("route_status", rd, 32'h0000_0039);
		route(1'b1, 32'h0000_0300, 1'b0);
		route(1'b1, 32'h0000_00ff, 1'b1);
		route(1'b1, 32'h0000_1100, 1'b0);
		apb(1'b1, `ADDR_BRIDGE_CONTROL, 32'hc);
		route(1'b1, 32'h0000_03c0, 1'b1);
		route(1'b1, 32'h0000_0200, 1'b0);
		apb(1'b1, `ADDR_MEM_LIMIT, 32'h0000_0100);
		route(1'b0, 32'h0100_0000, 1'b1);
		route(1'b0, 32'h010f_ffff, 1'b1);
		route(1'b0, 32'h00ff_ffff, 1'b0);
		route(1'b0, 32'h0110_0000, 1'b0);
		apb(1'b1, `ADDR_PREF_BASE, 32'h0000_0200);
		apb(1'b1, `ADDR_PREF_LIMIT, 32'h0000_0210);
		route(1'b0, 32'h021f_ffff, 1'b1);
		route(1'b0, 32'h0220_0000, 1'b0);
		$display("Windows done");
		gfx(1'b1, 1'b0, 32'hffff_ffff, 1'b0);
		gfx(1'b1, 1'b1, 32'h0, 1'b0);
		gfx(1'b0, 1'b1, 32'h0, 1'b1);
		gfx(1'b0, 1'b0, 32'h1234_5678, 1'b0);
		$display("Completions done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("graphics_port_reset", graphics_port_reset, 1'b1);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("graphics_port_reset", graphics_port_reset, 1'b0);
		apb(1'b0, `ADDR_BRIDGE_CONTROL, 32'h0);
		chk("bridge_control", rd, 32'h0);
		$display("Second reset done");
		stop_test;
	end
endmodule : tb_legacy_video_io_routing_decode
`default_nettype wire
